/* hw/party_line_pkg.sv */
// Constants and carriers for the two-card party-line interface.
// Assumes a 20 MHz system clock and host I/O strobes on that clock.
package party_line_pkg;
  localparam int WORD_W = 16;
  localparam int CLK_PERIOD_NS = 50;
  // Control word layout
  localparam int ADDR_LSB = 0;
  localparam int ADDR_W = 8;
  localparam int STATUS_LSB = 8;
  localparam int STATUS_W = 4;
  localparam int BIT_SEND_DATA = 12;
  localparam int BIT_TAKE_DATA = 13;
  localparam int BIT_SEND_STATUS = 14;
  localparam int BIT_INDIRECT = 15;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // Data strobe timing, least times in ns
  localparam int DRIVE_PULSE_NS = 1000;
  localparam int ALERT_DELAY_NS = 250;
  localparam int ALERT_PULSE_NS = 500;
  localparam int DRIVE_PULSE_CYC = (DRIVE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALERT_DELAY_CYC = (ALERT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ALERT_PULSE_CYC = (ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CNT_W = 8;
  localparam int FIFO_DEPTH = 16;
  // One-cycle host I/O instruction strobes for one card
  typedef struct packed {
    logic load_out;
    logic set_enable;
    logic clear_enable;
    logic clear_request;
    logic read_in;
  } card_op_t;
  typedef enum logic [1:0] {
    STROBE_IDLE = 2'b00,
    STROBE_DRIVE = 2'b01
  } strobe_state_t;
endpackage

/* hw/party_line_cards.sv */
// Command card and data card of a party-line I/O pair, plus the input FIFO.
// Assumes host I/O strobes on sys_clk_in; bus pins are resolved by the board.
// What this block does
// - Command card holds 16-bit in and out registers sharing one control bus.
// - Control lines are only pulled low, released unless sending control.
// - Command card gives an action-alert output and a done-return input.
// - Setting command enable drives the stored word and raises action-alert.
// - Done-return withdraws alert and word and latches bus into input register.
// - Data card holds 16-bit in and out registers on a data-only bus.
// - Data action-alert is level or pulse, chosen by a static jumper.
// - Data command enable starts a bus-drive pulse with alert pulse inside.
// - Data output register stays off the bus except during output transfers.
// - Data done-return latches the data bus and sets a request while enabled; sent with the data.
// - One interrupt channel; any command done-return sets the request flop.
// - Data command enable cleared outside outputs so inputs raise no interrupt.
`timescale 1ns/1ps

module sync2 #(
  parameter int W = 1
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

module word_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_q != DEPTH_C);
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem_q[wr_q] <= in_data_in;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

module party_line_cards
  import party_line_pkg::*;
#(
  parameter int FIFO_W = WORD_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Host side, command card
  input wire card_op_t ctl_op_in,
  input wire logic [WORD_W-1:0] ctl_word_in,
  output logic [WORD_W-1:0] ctl_in_word_out,
  output logic ctl_enable_out,
  output logic ctl_request_out,
  // Host side, data card
  input wire card_op_t dat_op_in,
  input wire logic [WORD_W-1:0] dat_word_in,
  output logic [WORD_W-1:0] dat_in_word_out,
  output logic dat_in_valid_out,
  output logic dat_room_out,
  output logic irq_out,
  // Control bus, ground-true open drain
  input wire logic [WORD_W-1:0] ctl_bus_in,
  output logic [WORD_W-1:0] ctl_bus_out,
  output logic [WORD_W-1:0] ctl_bus_oe_out,
  output logic ctl_alert_out,
  input wire logic ctl_done_in,
  // Data bus
  input wire logic [WORD_W-1:0] dat_bus_in,
  output logic [WORD_W-1:0] dat_bus_out,
  output logic dat_bus_oe_out,
  output logic dat_alert_out,
  input wire logic dat_done_in,
  input wire logic alert_level_sel_in
);
  localparam logic [STROBE_CNT_W-1:0] DRIVE_END = STROBE_CNT_W'(DRIVE_PULSE_CYC - 1);
  localparam logic [STROBE_CNT_W-1:0] ALERT_ON = STROBE_CNT_W'(ALERT_DELAY_CYC);
  localparam logic [STROBE_CNT_W-1:0] ALERT_OFF = STROBE_CNT_W'(ALERT_DELAY_CYC + ALERT_PULSE_CYC);

  logic [WORD_W-1:0] ctl_bus_s;
  logic [WORD_W-1:0] dat_bus_s;
  logic ctl_done_s;
  logic dat_done_s;
  logic level_sel_s;
  logic ctl_done_d1_q;
  logic dat_done_d1_q;

  sync2 #(.W(WORD_W)) u_sync_ctl_bus (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .async_in(ctl_bus_in), .sync_out(ctl_bus_s));
  sync2 #(.W(WORD_W)) u_sync_dat_bus (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .async_in(dat_bus_in), .sync_out(dat_bus_s));
  sync2 #(.W(3)) u_sync_ctl (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .async_in({ctl_done_in, dat_done_in, alert_level_sel_in}),
    .sync_out({ctl_done_s, dat_done_s, level_sel_s}));

  wire ctl_done_rise = ctl_done_s && !ctl_done_d1_q;
  wire dat_done_rise = dat_done_s && !dat_done_d1_q;

  // Command card
  logic [WORD_W-1:0] ctl_out_q;
  logic command_enable_flop_q;
  logic request_flop_q;
  logic command_enable_flop_d;
  logic request_flop_d;
  logic [WORD_W-1:0] ctl_oe_d;

  always_comb begin
    command_enable_flop_d = command_enable_flop_q;
    if (ctl_op_in.set_enable) begin
      command_enable_flop_d = 1'b1;
    end
    if (ctl_op_in.clear_enable || ctl_done_rise) begin
      command_enable_flop_d = 1'b0;
    end
  end

  // done sets request, set beats a clear in the same cycle
  always_comb begin
    request_flop_d = request_flop_q;
    if (ctl_op_in.clear_request || ctl_op_in.set_enable) begin
      request_flop_d = 1'b0;
    end
    if (ctl_done_rise) begin
      request_flop_d = 1'b1;
    end
  end

  // pull low only for set bits while sending
  assign ctl_oe_d = command_enable_flop_d ? ctl_out_q : '0;

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctl_out_q <= WORD_RESET;
      command_enable_flop_q <= 1'b0;
      request_flop_q <= 1'b0;
      ctl_done_d1_q <= 1'b0;
      dat_done_d1_q <= 1'b0;
    end else begin
      if (ctl_op_in.load_out) begin
        ctl_out_q <= ctl_word_in;
      end
      command_enable_flop_q <= command_enable_flop_d;
      request_flop_q <= request_flop_d;
      ctl_done_d1_q <= ctl_done_s;
      dat_done_d1_q <= dat_done_s;
    end
  end

  // input register sees the same 16 lines
  // latch bus on done-return, wire low reads as one
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctl_in_word_out <= WORD_RESET;
    end else if (ctl_done_rise) begin
      ctl_in_word_out <= ~ctl_bus_s;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctl_bus_oe_out <= '0;
      ctl_bus_out <= '0;
      ctl_alert_out <= 1'b0;
      ctl_enable_out <= 1'b0;
      ctl_request_out <= 1'b0;
    end else begin
      ctl_bus_oe_out <= ctl_oe_d;
      ctl_bus_out <= '0;
      ctl_alert_out <= command_enable_flop_d;
      ctl_enable_out <= command_enable_flop_d;
      ctl_request_out <= request_flop_d;
    end
  end

  // Data card
  logic [WORD_W-1:0] dat_out_q;
  logic dat_enable_q;
  logic dat_request_q;
  strobe_state_t strobe_q;
  strobe_state_t strobe_d;
  logic [STROBE_CNT_W-1:0] strobe_cnt_q;
  logic [STROBE_CNT_W-1:0] strobe_cnt_d;
  logic dat_enable_d;
  logic dat_request_d;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_W-1:0] fifo_out_data;

  always_comb begin
    strobe_d = strobe_q;
    strobe_cnt_d = strobe_cnt_q;
    case (strobe_q)
      STROBE_IDLE: begin
        strobe_cnt_d = '0;
        if (dat_op_in.set_enable) begin
          strobe_d = STROBE_DRIVE;
        end
      end
      STROBE_DRIVE: begin
        strobe_cnt_d = strobe_cnt_q + 1'b1;
        if (strobe_cnt_q == DRIVE_END) begin
          strobe_d = STROBE_IDLE;
          strobe_cnt_d = '0;
        end
      end
      default: begin
        strobe_d = STROBE_IDLE;
        strobe_cnt_d = '0;
      end
    endcase
  end

  wire drive_d = (strobe_d == STROBE_DRIVE);
  // alert pulse sits inside the drive pulse
  wire alert_pulse_d = drive_d && (strobe_cnt_d >= ALERT_ON) && (strobe_cnt_d < ALERT_OFF);
  wire alert_d = level_sel_s ? (dat_enable_d && drive_d) : alert_pulse_d;

  // enable flop only set by output transfers, software clears it
  always_comb begin
    dat_enable_d = dat_enable_q;
    if (dat_op_in.set_enable) begin
      dat_enable_d = 1'b1;
    end
    if (dat_op_in.clear_enable) begin
      dat_enable_d = 1'b0;
    end
  end

  // done raises a request only while enabled
  always_comb begin
    dat_request_d = dat_request_q;
    if (dat_op_in.clear_request || dat_op_in.set_enable) begin
      dat_request_d = 1'b0;
    end
    if (dat_done_rise && dat_enable_q) begin
      dat_request_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dat_out_q <= WORD_RESET;
      dat_enable_q <= 1'b0;
      dat_request_q <= 1'b0;
      strobe_q <= STROBE_IDLE;
      strobe_cnt_q <= '0;
    end else begin
      if (dat_op_in.load_out) begin
        dat_out_q <= dat_word_in;
      end
      dat_enable_q <= dat_enable_d;
      dat_request_q <= dat_request_d;
      strobe_q <= strobe_d;
      strobe_cnt_q <= strobe_cnt_d;
    end
  end

  // drive only inside the output pulse
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dat_bus_out <= '0;
      dat_bus_oe_out <= 1'b0;
      dat_alert_out <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      dat_bus_out <= drive_d ? dat_out_q : '0;
      dat_bus_oe_out <= drive_d;
      dat_alert_out <= alert_d;
      irq_out <= request_flop_d || dat_request_d;
    end
  end

  // data done-return captures the bus into the FIFO, and requests while enabled
  word_fifo #(.W(FIFO_W), .DEPTH(FIFO_D)) u_in_fifo (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .in_valid_in(dat_done_rise),
    .in_ready_out(fifo_in_ready),
    .in_data_in(dat_bus_s),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(dat_op_in.read_in),
    .out_data_out(fifo_out_data)
  );

  // Head word is shown registered; a word arriving while full is lost
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dat_in_word_out <= WORD_RESET;
      dat_in_valid_out <= 1'b0;
      dat_room_out <= 1'b0;
    end else begin
      // Hold the last word while empty, so unwritten FIFO slots never show
      if (fifo_out_valid) begin
        dat_in_word_out <= fifo_out_data;
      end
      dat_in_valid_out <= fifo_out_valid && !(dat_op_in.read_in && fifo_out_valid);
      dat_room_out <= fifo_in_ready;
    end
  end
endmodule

/* verification/party_line_asserts.sv */
// Checker for the party-line card pair, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module party_line_asserts
  import party_line_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire card_op_t ctl_op_in,
  input wire logic [WORD_W-1:0] ctl_word_in,
  input wire logic [WORD_W-1:0] ctl_bus_out,
  input wire logic [WORD_W-1:0] ctl_bus_oe_out,
  input wire logic ctl_enable_out,
  input wire logic ctl_request_out,
  input wire logic irq_out,
  input wire logic ctl_alert_out,
  input wire logic ctl_done_in,
  input wire card_op_t dat_op_in,
  input wire logic dat_bus_oe_out,
  input wire logic dat_alert_out,
  input wire logic alert_level_sel_in
);
  logic [WORD_W-1:0] word_q;
  logic [7:0] oe_cnt_q;
  logic [7:0] al_cnt_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge sys_clk_in) begin
    if (ctl_op_in.load_out) word_q <= ctl_word_in;
    oe_cnt_q <= dat_bus_oe_out ? oe_cnt_q + 8'h01 : 8'h00;
    al_cnt_q <= dat_alert_out ? al_cnt_q + 8'h01 : 8'h00;
  end
  property p_set; ctl_op_in.set_enable |=> ctl_alert_out && ctl_enable_out; endproperty
  a_set: assert property (p_set) else $error("alert not raised");
  property p_word; ctl_alert_out |-> ctl_bus_oe_out == word_q; endproperty
  a_word: assert property (p_word) else $error("bus word differs");
  property p_idle; !ctl_alert_out |-> (ctl_bus_oe_out | ctl_bus_out) == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("control line held");
  property p_done; $rose(ctl_done_in) && ctl_alert_out |-> ##[2:4] !ctl_alert_out && ctl_bus_oe_out == 16'h0000; endproperty
  a_done: assert property (p_done) else $error("alert not withdrawn");
  property p_req; $rose(ctl_done_in) |-> ##[2:4] ctl_request_out && irq_out; endproperty
  a_req: assert property (p_req) else $error("no request");
  property p_drive; $fell(dat_bus_oe_out) |-> oe_cnt_q == DRIVE_PULSE_CYC; endproperty
  a_drive: assert property (p_drive) else $error("drive width");
  property p_inside; dat_alert_out |-> dat_bus_oe_out; endproperty
  a_inside: assert property (p_inside) else $error("alert outside drive");
  property p_pulse; $fell(dat_alert_out) && !alert_level_sel_in |-> al_cnt_q == ALERT_PULSE_CYC; endproperty
  a_pulse: assert property (p_pulse) else $error("alert width");
  property p_level; alert_level_sel_in && dat_bus_oe_out |-> dat_alert_out; endproperty
  a_level: assert property (p_level) else $error("level alert missing");
  c_status: cover property ($rose(ctl_done_in) && ctl_alert_out);
  c_out: cover property ($fell(dat_bus_oe_out));
  c_level: cover property (alert_level_sel_in && dat_alert_out);
endmodule
bind party_line_cards party_line_asserts chk_u (.*);

/* verification/party_line_ctrl_model.sv */
// Behavioural party-line peripheral controller at one fixed address.
// Assumes the bench resolves the pulled-low control lines and the data bus.
`timescale 1ns/1ps
module party_line_ctrl_model #(
  parameter logic [7:0] DEV_ADDR = 8'h30
) (
  input wire logic sys_clk_in,
  input wire logic [15:0] ctl_word_in,
  input wire logic ctl_alert_in,
  input wire logic [15:0] dat_bus_in,
  input wire logic dat_alert_in,
  input wire logic slow_in,
  input wire logic ident_in,
  input wire logic [3:0] status_in,
  input wire logic [15:0] send_word_in,
  output logic [15:0] ctl_pull_out,
  output logic ctl_done_out,
  output logic [15:0] dat_word_out,
  output logic dat_oe_out,
  output logic dat_done_out,
  output logic [15:0] took_word_out
);
  logic [15:0] cmd;
  int n;
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask
  initial begin
    {ctl_pull_out, ctl_done_out, dat_word_out, dat_oe_out, dat_done_out, took_word_out} = '0;
    forever begin
      tick;
      if (ident_in && !ctl_alert_in) begin
        ctl_pull_out = {8'h00, DEV_ADDR};
        ctl_done_out = 1'b1;
      end else if (ctl_alert_in && ctl_word_in[7:0] == DEV_ADDR) begin
        cmd = ctl_word_in;
        repeat (slow_in ? 8 : 1) tick;
        n = 0;
        // take the word inside the data alert
        while (cmd[13] && !dat_alert_in && n < 60) begin
          tick;
          n++;
        end
        if (cmd[13]) took_word_out = dat_bus_in;
        // data goes out with its done
        if (cmd[12]) {dat_word_out, dat_oe_out, dat_done_out} = {send_word_in, 2'b11};
        // status on bits 8 to 11
        if (cmd[14]) ctl_pull_out[11:8] = status_in;
        tick;
        ctl_done_out = 1'b1;
      end
      n = 0;
      while (ctl_done_out && ctl_alert_in && n < 60) begin
        tick;
        n++;
      end
      if (ctl_done_out) begin
        repeat (6) tick;
        // all lines let go once done
        {ctl_pull_out, ctl_done_out, dat_oe_out, dat_done_out} = '0;
      end
    end
  end
endmodule

/* verification/party_line_bus_interface_tb.sv */
// Bench for the party-line card pair facing one controller model.
// Assumes pull-ups on the control lines and a 20 MHz clock.
`timescale 1ns/1ps
module party_line_bus_interface_tb;
  import party_line_pkg::*;
  localparam logic [7:0] DEV = 8'h30;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  card_op_t ctl_op_in = '0;
  card_op_t dat_op_in = '0;
  logic [15:0] ctl_word_in = 16'h0000;
  logic [15:0] dat_word_in = 16'h0000;
  logic [15:0] send = 16'h0000;
  logic [15:0] dat_last = 16'h0000;
  logic alert_level_sel_in = 1'b0;
  logic slow = 1'b0;
  logic ident = 1'b0;
  logic [3:0] status = 4'h0;
  logic [15:0] ctl_in_word_out, dat_in_word_out, ctl_bus_in, ctl_bus_out, ctl_bus_oe_out, dat_bus_in, dat_bus_out;
  logic [15:0] pull, m_word, took;
  logic ctl_enable_out, ctl_request_out, dat_in_valid_out, dat_room_out, irq_out, ctl_alert_out, ctl_done_in;
  logic dat_bus_oe_out, dat_alert_out, dat_done_in, m_oe;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  assign ctl_bus_in = ~((ctl_bus_oe_out & ~ctl_bus_out) | pull);
  // Released data lines show the inverse of their last value
  assign dat_bus_in = dat_bus_oe_out ? dat_bus_out : (m_oe ? m_word : ~dat_last);
  party_line_cards dut_u (.*);
  party_line_ctrl_model #(.DEV_ADDR(DEV)) m_u (.sys_clk_in, .ctl_word_in(~ctl_bus_in),
    .ctl_alert_in(ctl_alert_out), .dat_bus_in, .dat_alert_in(dat_alert_out), .slow_in(slow),
    .ident_in(ident), .status_in(status), .send_word_in(send), .ctl_pull_out(pull), .ctl_done_out(ctl_done_in),
    .dat_word_out(m_word), .dat_oe_out(m_oe), .dat_done_out(dat_done_in), .took_word_out(took));
  initial forever #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) begin
    cycles++;
    if (dat_bus_oe_out | m_oe) dat_last <= dat_bus_in;
    if (cycles == 5000) begin
      n_mismatch++;
      stop_test;
    end
  end
  task automatic tick;
    @(posedge sys_clk_in);
    #1;
  endtask
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic op(input logic c, input card_op_t o, input logic [15:0] w);
    if (c) {ctl_op_in, ctl_word_in} = {o, w};
    else {dat_op_in, dat_word_in} = {o, w};
    tick;
    {ctl_op_in, dat_op_in} = '0;
    tick;
  endtask
  task automatic wait_drop;
    int n;
    n = 0;
    while (ctl_alert_out && n < 100) begin
      tick;
      n++;
    end
    chk("alert drop", ctl_alert_out, 16'h0000);
  endtask
  task automatic t_status(input logic [15:0] w, input logic [3:0] s, input logic sl);
    {status, slow} = {s, sl};
    op(1'b1, 5'b10000, w);
    op(1'b1, 5'b01000, 16'h0000);
    chk("bus word", ctl_bus_oe_out, w);
    chk("alert", {ctl_alert_out, ctl_enable_out}, 16'h0003);
    wait_drop;
    chk("status word", ctl_in_word_out, w | {4'h0, s, 8'h00});
    chk("request", {ctl_request_out, irq_out}, 16'h0003);
    chk("bus released", ctl_bus_oe_out, 16'h0000);
    repeat (8) tick;
  endtask
  task automatic t_out(input logic lvl);
    logic [15:0] d, n_oe, n_al;
    {alert_level_sel_in, slow, n_oe, n_al, d} = {lvl, 49'h0};
    op(1'b1, 5'b10000, {8'h20, DEV});
    op(1'b1, 5'b01000, 16'h0000);
    op(1'b0, 5'b10000, {15'h2d1e, lvl});
    dat_op_in = 5'b01000;
    tick;
    dat_op_in = '0;
    for (int k = 0; k < 40; k++) begin
      if (dat_alert_out && n_al == 0) d = n_oe;
      n_al += dat_alert_out;
      n_oe += dat_bus_oe_out;
      tick;
    end
    chk("drive width", n_oe, 16'(DRIVE_PULSE_CYC));
    chk("alert width", n_al, lvl ? 16'(DRIVE_PULSE_CYC) : 16'(ALERT_PULSE_CYC));
    chk("alert delay", d, lvl ? 16'h0000 : 16'(ALERT_DELAY_CYC));
    wait_drop;
    chk("taken word", took, {15'h2d1e, lvl});
    op(1'b0, 5'b00100, 16'h0000);
    repeat (8) tick;
  endtask
  task automatic t_in(input logic [15:0] w);
    send = w;
    op(1'b1, 5'b10000, {8'h10, DEV});
    op(1'b1, 5'b01000, 16'h0000);
    wait_drop;
    repeat (8) tick;
  endtask
  task automatic t_fifo;
    chk("idle data word", dat_in_word_out, WORD_RESET);
    for (int i = 0; i < 16; i++) t_in(16'h0100 + 16'(i));
    chk("fifo full", dat_room_out, 16'h0000);
    chk("fifo valid", dat_in_valid_out, 16'h0001);
    t_in(16'hbeef);
    op(1'b1, 5'b00010, 16'h0000);
    chk("data irq", irq_out, 16'h0000);
    for (int i = 0; i < 16; i++) begin
      chk("fifo head", dat_in_word_out, 16'h0100 + 16'(i));
      op(1'b0, 5'b00001, 16'h0000);
      tick;
    end
    chk("fifo empty", dat_in_valid_out, 16'h0000);
  endtask
  task automatic t_ident;
    int n;
    ident = 1'b1;
    repeat (2) tick;
    ident = 1'b0;
    n = 0;
    while (!ctl_request_out && n < 30) begin
      tick;
      n++;
    end
    chk("ident", {ctl_request_out, irq_out, ctl_in_word_out[7:0]}, {2'b11, DEV});
  endtask
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    #1;
    rst_in = 1'b0;
    chk("reset flags", {ctl_enable_out, ctl_request_out, irq_out, dat_bus_oe_out, dat_in_valid_out}, 16'h0000);
    chk("reset word", ctl_in_word_out, WORD_RESET);
    t_status({8'h40, DEV}, 4'ha, 1'b0);
    t_status({8'hc0, DEV}, 4'h5, 1'b1);
    t_out(1'b0);
    t_out(1'b1);
    t_fifo;
    t_ident;
    stop_test;
  end
endmodule
